//--- rtl/crc_scan_pkg.sv
// Register map, field positions and reset values of the CRC memory scanner
package crc_scan_pkg;
  // Register bus geometry, scan pointer, polynomial and trigger sizes
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int SCAN_ADDR_W = 22;
  localparam int POLY_W = 16;
  localparam int TRIG_N = 16;
  localparam int TSEL_W = 4;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_SHIFT_LOW = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_POLY_HIGH = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_POLY_LOW = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_CUR_UPPER = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_CUR_HIGH = 4'h5;
  localparam logic [ADDR_W-1:0] OFS_CUR_LOW = 4'h6;
  localparam logic [ADDR_W-1:0] OFS_END_UPPER = 4'h7;
  localparam logic [ADDR_W-1:0] OFS_END_HIGH = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_END_LOW = 4'h9;
  localparam logic [ADDR_W-1:0] OFS_TRIG_SEL = 4'hA;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'hB;

  // Control and status register fields
  localparam int CTL_EN = 7;
  localparam int CTL_TRIG = 6;
  localparam int CTL_GO = 5;
  localparam int CTL_REGION = 2;
  localparam int CTL_BURST = 1;
  localparam int CTL_BUSY = 0;
  localparam int STAT_DONE = 0;

  // Address byte slices
  localparam int UPPER_W = 6;
  localparam int HIGH_LSB = 8;
  localparam int UPPER_LSB = 16;

  // Highest trigger select code that names a real source
  localparam logic [TSEL_W-1:0] TSEL_LAST = 4'h9;

  // Reset values
  localparam logic [SCAN_ADDR_W-1:0] CUR_RESET = 22'h000000;
  localparam logic [SCAN_ADDR_W-1:0] END_RESET = 22'h3FFFFF;
  localparam logic [POLY_W-1:1] POLY_RESET = 15'h0000;
  localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
  localparam logic [TSEL_W-1:0] TSEL_RESET = 4'h0;

  // Fetch sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_PUSH = 3'b100
  } scan_state_t;
endpackage

//--- rtl/scan_addr_step.sv
// Next-address and end-of-scan compare for the scanner address pointer
`timescale 1ns/1ps
module scan_addr_step
  import crc_scan_pkg::*;
(
  input wire logic [SCAN_ADDR_W-1:0] cur_addr,
  input wire logic [SCAN_ADDR_W-1:0] end_addr,
  output logic [SCAN_ADDR_W-1:0] next_addr,
  output logic past_end,
  output logic at_end
);
  // Wraps at the top of the 22-bit space; a scan ending at 3FFFFF wraps to 0 and never goes past the end
  assign next_addr = cur_addr + {{(SCAN_ADDR_W-1){1'b0}}, 1'b1};
  // Pointer already beyond the last address
  assign past_end = cur_addr > end_addr;
  // Fetching the last address moves the pointer past the end, except an end of 3FFFFF, which wraps to 0
  assign at_end = cur_addr == end_addr;
endmodule

//--- rtl/crc_memory_scanner.sv
// Memory scanner feeding the CRC engine, with its registers
//
// The implementer's own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module crc_memory_scanner
  import crc_scan_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic [DATA_W-1:0] crc_shifter_low,
  input wire logic crc_engine_on,
  input wire logic crc_engine_go,
  input wire logic crc_ready,
  output logic [DATA_W-1:0] crc_data,
  output logic crc_data_valid,
  output logic [POLY_W-1:0] poly_tap,
  input wire logic [TRIG_N-1:0] trig_src,
  output logic mem_req,
  input wire logic mem_grant,
  input wire logic higher_pending,
  output logic [SCAN_ADDR_W-1:0] mem_addr,
  output logic mem_region,
  input wire logic [DATA_W-1:0] mem_rdata,
  output logic lower_blocked,
  output logic lower_cycle_free,
  output logic scan_done_flag
);
  // Software-visible state
  logic scanner_enable_q; // Scanner on/off
  logic trigger_gate_on_q; // Requests wait on trigger outside burst
  logic scanner_go_q; // Scan in progress
  logic region_select_q; // One selects data EEPROM
  logic burst_request_q; // Request held continuously
  logic [POLY_W-1:1] poly_tap_q; // Tap enables, bit 0 fixed
  logic [SCAN_ADDR_W-1:0] scan_current_addr_q; // Next address to fetch
  logic [SCAN_ADDR_W-1:0] scan_end_addr_q; // Last address of the scan
  logic [TSEL_W-1:0] trig_sel_q; // Trigger source select
  logic scan_done_q; // Sticky end-of-scan flag
  logic [DATA_W-1:0] rdata_q; // Read data, one cycle late
  // Fetch datapath
  scan_state_t state_q;
  logic [DATA_W-1:0] crc_data_q; // Word waiting for the engine
  logic [SCAN_ADDR_W-1:0] fetch_addr_q; // Address driven to memory
  logic fetch_region_q; // Region of the fetch in flight
  // Trigger synchroniser, the first stage is read only by the second
  logic [TRIG_N-1:0] trig_meta_q;
  logic [TRIG_N-1:0] trig_sync_q;
  // Combinational helpers
  logic [SCAN_ADDR_W-1:0] next_addr;
  logic past_end;
  logic at_end;
  logic trig_true;
  logic scan_active;
  logic take;
  logic busy;
  logic wr_ctl;
  logic wr_addr_ok;

  // Shared compare and increment
  scan_addr_step u_step (
    .cur_addr(scan_current_addr_q),
    .end_addr(scan_end_addr_q),
    .next_addr(next_addr),
    .past_end(past_end),
    .at_end(at_end)
  );

  // Trigger pins come from other clock domains
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trig_meta_q <= '0;
      trig_sync_q <= '0;
    end else begin
      trig_meta_q <= trig_src;
      trig_sync_q <= trig_meta_q;
    end
  end

  // Reserved select codes never fire
  assign trig_true = (trig_sel_q <= TSEL_LAST) && trig_sync_q[trig_sel_q];

  assign scan_active = scanner_enable_q && scanner_go_q;
  assign busy = state_q != ST_IDLE;
  assign wr_ctl = reg_wr && (reg_addr == OFS_CONTROL);
  // Pointer bytes are frozen for the whole scan
  assign wr_addr_ok = reg_wr && !scanner_go_q;

  // Request generation per mode
  always_comb begin
    mem_req = 1'b0;
    if (scan_active && !past_end) begin
      if (burst_request_q) begin
        mem_req = 1'b1;
      end else if (trigger_gate_on_q) begin
        mem_req = !busy && crc_ready && trig_true;
      end else begin
        mem_req = !busy && crc_ready;
      end
    end
  end

  // A grant is only ours when nobody above us is asking
  assign take = mem_req && mem_grant && !higher_pending && !busy;
  // Burst owns the bus below our level until go drops
  assign lower_blocked = scan_active && burst_request_q;
  // Outside burst every cycle we do not take is free for lower levels
  assign lower_cycle_free = !lower_blocked && !take;

  // Sequencer: take, wait one cycle for memory, hand to engine
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (take) begin
            state_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          state_q <= ST_PUSH;
        end
        ST_PUSH: begin
          // Hold the word until the engine accepts it
          if (crc_ready) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Fetch address and region registered toward memory
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fetch_addr_q <= CUR_RESET;
      fetch_region_q <= 1'b0;
    end else if (take) begin
      fetch_addr_q <= scan_current_addr_q;
      fetch_region_q <= region_select_q;
    end
  end
  assign mem_addr = fetch_addr_q;
  assign mem_region = fetch_region_q;

  // Capture the fetched word exactly once
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      crc_data_q <= BYTE_ZERO;
    end else if (state_q == ST_WAIT) begin
      crc_data_q <= mem_rdata;
    end
  end
  assign crc_data = crc_data_q;
  assign crc_data_valid = state_q == ST_PUSH;

  // Current address: loads from software while go is clear, steps on each take
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scan_current_addr_q <= CUR_RESET;
    end else if (take) begin
      scan_current_addr_q <= next_addr;
    end else if (wr_addr_ok) begin
      unique case (reg_addr)
        OFS_CUR_UPPER: scan_current_addr_q[SCAN_ADDR_W-1:UPPER_LSB] <= reg_wdata[UPPER_W-1:0];
        OFS_CUR_HIGH: scan_current_addr_q[UPPER_LSB-1:HIGH_LSB] <= reg_wdata;
        OFS_CUR_LOW: scan_current_addr_q[HIGH_LSB-1:0] <= reg_wdata;
        default: begin
        end
      endcase
    end
  end

  // End address, also frozen while scanning
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scan_end_addr_q <= END_RESET;
    end else if (wr_addr_ok) begin
      unique case (reg_addr)
        OFS_END_UPPER: scan_end_addr_q[SCAN_ADDR_W-1:UPPER_LSB] <= reg_wdata[UPPER_W-1:0];
        OFS_END_HIGH: scan_end_addr_q[UPPER_LSB-1:HIGH_LSB] <= reg_wdata;
        OFS_END_LOW: scan_end_addr_q[HIGH_LSB-1:0] <= reg_wdata;
        default: begin
        end
      endcase
    end
  end

  // Go bit: software sets or clears, hardware clears
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scanner_go_q <= 1'b0;
    end else if (scanner_go_q && ((past_end && !busy) || !crc_engine_go)) begin
      // Hardware stop beats a software write in the same cycle
      scanner_go_q <= 1'b0;
    end else if (wr_ctl) begin
      scanner_go_q <= reg_wdata[CTL_GO];
    end
  end

  // Remaining control bits, plain storage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scanner_enable_q <= 1'b0;
      trigger_gate_on_q <= 1'b0;
      region_select_q <= 1'b0;
      burst_request_q <= 1'b0;
    end else if (wr_ctl) begin
      scanner_enable_q <= reg_wdata[CTL_EN];
      trigger_gate_on_q <= reg_wdata[CTL_TRIG];
      region_select_q <= reg_wdata[CTL_REGION];
      burst_request_q <= reg_wdata[CTL_BURST];
    end
  end

  // Polynomial taps and trigger select
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      poly_tap_q <= POLY_RESET;
      trig_sel_q <= TSEL_RESET;
    end else if (reg_wr) begin
      if (reg_addr == OFS_POLY_HIGH) begin
        poly_tap_q[POLY_W-1:DATA_W] <= reg_wdata;
      end
      if (reg_addr == OFS_POLY_LOW) begin
        poly_tap_q[DATA_W-1:1] <= reg_wdata[DATA_W-1:1];
      end
      if (reg_addr == OFS_TRIG_SEL) begin
        trig_sel_q <= reg_wdata[TSEL_W-1:0];
      end
    end
  end
  assign poly_tap = {poly_tap_q, 1'b1};

  // Done flag: the hardware set wins over a software clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scan_done_q <= 1'b0;
    end else if (take && at_end) begin
      scan_done_q <= 1'b1;
    end else if (reg_wr && (reg_addr == OFS_STATUS) && reg_wdata[STAT_DONE]) begin
      scan_done_q <= 1'b0;
    end
  end
  assign scan_done_flag = scan_done_q;

  // Read mux, data stands only in the cycle after the strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q <= BYTE_ZERO;
    end else if (reg_rd) begin
      unique case (reg_addr)
        OFS_SHIFT_LOW: rdata_q <= crc_shifter_low;
        OFS_POLY_HIGH: rdata_q <= poly_tap_q[POLY_W-1:DATA_W];
        OFS_POLY_LOW: rdata_q <= {poly_tap_q[DATA_W-1:1], 1'b1};
        OFS_CONTROL: rdata_q <= {scanner_enable_q, trigger_gate_on_q, scanner_go_q, 2'b00,
                                 region_select_q, burst_request_q, busy};
        OFS_CUR_UPPER: rdata_q <= {2'b00, scan_current_addr_q[SCAN_ADDR_W-1:UPPER_LSB]};
        OFS_CUR_HIGH: rdata_q <= scan_current_addr_q[UPPER_LSB-1:HIGH_LSB];
        OFS_CUR_LOW: rdata_q <= scan_current_addr_q[HIGH_LSB-1:0];
        OFS_END_UPPER: rdata_q <= {2'b00, scan_end_addr_q[SCAN_ADDR_W-1:UPPER_LSB]};
        OFS_END_HIGH: rdata_q <= scan_end_addr_q[UPPER_LSB-1:HIGH_LSB];
        OFS_END_LOW: rdata_q <= scan_end_addr_q[HIGH_LSB-1:0];
        OFS_TRIG_SEL: rdata_q <= {4'h0, trig_sel_q};
        OFS_STATUS: rdata_q <= {7'h00, scan_done_q};
        default: rdata_q <= BYTE_ZERO;
      endcase
    end else begin
      rdata_q <= BYTE_ZERO;
    end
  end
  assign reg_rdata = rdata_q;

  // Checks on the scanner's own outputs and internal state
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_plain_req_ready: assert property (mem_req && !burst_request_q |-> crc_ready)
    else $error("request without engine ready");
  a_trig_req_gate: assert property (mem_req && !burst_request_q && trigger_gate_on_q
    |-> trig_true)
    else $error("trigger mode request without trigger");
  a_burst_req_hold: assert property (scan_active && burst_request_q && !past_end |-> mem_req)
    else $error("burst request dropped");
  a_grant_higher_wins: assert property (higher_pending && !busy |=> state_q != ST_WAIT)
    else $error("fetch with higher requester pending");
  a_addr_step_once: assert property (take |=> scan_current_addr_q == $past(next_addr)
    && state_q == ST_WAIT ##1 state_q == ST_PUSH)
    else $error("address did not step on fetch");
  a_addr_write_frozen: assert property (scanner_go_q && !take |=>
    scan_current_addr_q == $past(scan_current_addr_q))
    else $error("address changed while scanning");
  a_go_engine_stop: assert property (scanner_go_q && !crc_engine_go |=> !scanner_go_q)
    else $error("go not cleared by engine stop");
  a_done_past_end: assert property (take && at_end |=> scan_done_q [*2])
    else $error("done flag not set at end");
  a_deliver_word: assert property (state_q == ST_WAIT |=> crc_data_valid
    && crc_data == $past(mem_rdata))
    else $error("fetched word not presented");
  a_busy_after_take: assert property (take |=> busy [*2])
    else $error("busy not shown during cycle");
  a_shift_view_read: assert property (reg_rd && reg_addr == OFS_SHIFT_LOW
    |=> reg_rdata == $past(crc_shifter_low))
    else $error("shifter view mismatch");
  a_poly_bit_zero: assert property (reg_rd && reg_addr == OFS_POLY_LOW |=> reg_rdata[0])
    else $error("tap bit zero not one");
  a_burst_blocks_lower: assert property (scan_active && burst_request_q |-> !lower_cycle_free)
    else $error("lower requester granted in burst");

  c_plain_fetch: cover property (!burst_request_q && take ##2 crc_data_valid && crc_ready);
  c_burst_stall: cover property (burst_request_q && crc_data_valid && !crc_ready);
  c_scan_end: cover property (take && at_end ##[1:8] !scanner_go_q);
  c_trig_fetch: cover property (trigger_gate_on_q && take);
endmodule

//--- verification/scan_far_side.sv
// Far-side model: system arbiter, scanned memory and CRC engine input handshake
`timescale 1ns/1ps
module scan_far_side (
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] ready_mode,
  input wire logic contend,
  input wire logic mem_req,
  input wire logic [21:0] mem_addr,
  input wire logic mem_region,
  output logic mem_grant,
  output logic higher_pending,
  output logic [7:0] mem_rdata,
  output logic crc_ready
);
  logic [7:0] lfsr_q; // Private noise for stalls and contention
  logic fetch_q; // A take may have landed at the last edge
  logic [7:0] word; // Memory contents at the presented address

  // Stall and contention pattern; ready mode 0 prompt, 1 random, 2 never
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lfsr_q <= 8'h5B;
      fetch_q <= 1'h0;
      higher_pending <= 1'h0;
      crc_ready <= 1'h0;
    end else begin
      lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
      fetch_q <= mem_req && mem_grant && !higher_pending;
      higher_pending <= contend && lfsr_q[0];
      crc_ready <= (ready_mode == 2'h0) || (ready_mode == 2'h1 && lfsr_q[2]);
    end
  end

  // Grant only with no higher requester pending
  assign mem_grant = mem_req && !higher_pending;
  // Each region holds different contents so a wrong region shows
  assign word = mem_addr[7:0] ^ mem_addr[15:8] ^ (mem_region ? 8'h5A : 8'h00);
  // Data only valid the cycle after a grant; inverted otherwise
  assign mem_rdata = fetch_q ? word : ~word;
endmodule

//--- verification/crc_memory_scanner_test.sv
// Self-checking testbench of the CRC memory scanner
`timescale 1ns/1ps
module crc_memory_scanner_test
  import crc_scan_pkg::*;
;
  logic clk, rst, reg_wr, reg_rd, crc_engine_on, crc_engine_go, crc_ready, crc_data_valid;
  logic mem_req, mem_grant, higher_pending, mem_region, lower_blocked, scan_done_flag;
  logic lower_cycle_free, contend, rd_seen;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata, crc_shifter_low, crc_data, mem_rdata;
  logic [POLY_W-1:0] poly_tap;
  logic [TRIG_N-1:0] trig_src;
  logic [SCAN_ADDR_W-1:0] mem_addr, s, e;
  logic [1:0] ready_mode;
  logic [7:0] v, h, ctl;
  logic [7:0] ctls [3] = '{8'hA0, 8'hA6, 8'hE4}; // Plain, burst, trigger modes
  logic [31:0] seed_q = 32'h00000032;
  logic [7:0] rd_q[$], data_q[$]; // Expected read data and delivered words
  string nm_q[$];
  int fail_count = 0, checks_done = 0, i, k;

  crc_memory_scanner DUT (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .crc_shifter_low(crc_shifter_low),
    .crc_engine_on(crc_engine_on), .crc_engine_go(crc_engine_go), .crc_ready(crc_ready),
    .crc_data(crc_data), .crc_data_valid(crc_data_valid), .poly_tap(poly_tap),
    .trig_src(trig_src), .mem_req(mem_req), .mem_grant(mem_grant),
    .higher_pending(higher_pending), .mem_addr(mem_addr), .mem_region(mem_region),
    .mem_rdata(mem_rdata), .lower_blocked(lower_blocked),
    .lower_cycle_free(lower_cycle_free), .scan_done_flag(scan_done_flag));
  scan_far_side far (.clk(clk), .rst(rst), .ready_mode(ready_mode), .contend(contend),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_region(mem_region), .mem_grant(mem_grant),
    .higher_pending(higher_pending), .mem_rdata(mem_rdata), .crc_ready(crc_ready));

  // Free-running 10 MHz clock
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end

  // Xorshift source seeded at 50
  function automatic logic [31:0] xs();
    seed_q = seed_q ^ (seed_q << 13);
    seed_q = seed_q ^ (seed_q >> 17);
    seed_q = seed_q ^ (seed_q << 5);
    return seed_q;
  endfunction

  // One comparison, counted
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Single-cycle register write
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask

  // Single-cycle register read; the monitor checks the answer
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] x, input string nm);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    rd_q.push_back(x);
    nm_q.push_back(nm);
    @(posedge clk);
    reg_rd <= 1'h0;
  endtask

  // Program both address pointers, note expected words, then start
  task automatic scan_start(input logic [7:0] c, input logic [21:0] a0, input logic [21:0] a1,
                            input bit fill);
    logic [21:0] a;
    wr(OFS_CUR_UPPER, {2'h0, a0[21:16]});
    wr(OFS_CUR_HIGH, a0[15:8]);
    wr(OFS_CUR_LOW, a0[7:0]);
    wr(OFS_END_UPPER, {2'h0, a1[21:16]});
    wr(OFS_END_HIGH, a1[15:8]);
    wr(OFS_END_LOW, a1[7:0]);
    for (a = a0; fill && a <= a1; a++) begin
      data_q.push_back(a[7:0] ^ a[15:8] ^ (c[CTL_REGION] ? 8'h5A : 8'h00));
    end
    wr(OFS_CONTROL, c);
  endtask

  // Wait for all words, then check go, pointer and done flag
  task automatic scan_end(input logic [7:0] c, input logic [21:0] a1);
    for (int n = 0; n < 3000 && data_q.size() > 0; n++) @(posedge clk);
    repeat (4) @(posedge clk);
    chk("words_left", 32'h0, 32'(data_q.size()));
    rd(OFS_CONTROL, c & 8'hDF, "control");
    rd(OFS_CUR_LOW, 8'(a1[7:0] + 8'h01), "cur_low");
    rd(OFS_STATUS, 8'h01, "done_flag");
    chk("scan_done_flag", 32'h1, {31'h0, scan_done_flag});
    wr(OFS_STATUS, 8'h01);
    rd(OFS_STATUS, 8'h00, "done_flag");
    chk("scan_done_flag", 32'h0, {31'h0, scan_done_flag});
  endtask

  // Monitor: read answers one cycle after the strobe, and engine deliveries
  always @(posedge clk) begin
    if (rd_seen === 1'h1 && rd_q.size() > 0) begin
      chk(nm_q.pop_front(), {24'h0, rd_q.pop_front()}, {24'h0, reg_rdata});
    end
    rd_seen <= reg_rd;
    if (crc_data_valid === 1'h1 && crc_ready === 1'h1) begin
      if (data_q.size() > 0) chk("crc_data", {24'h0, data_q.pop_front()}, {24'h0, crc_data});
      else chk("extra_word", 32'h0, 32'h1);
    end
  end

  // Verdict and end of run
  task automatic tally_and_finish();
    if (fail_count == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Watchdog well past the expected few hundred cycles
  initial begin
    #(60000 * 100);
    fail_count++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    rst = 1'h1;
    {reg_addr, reg_wdata, reg_wr, reg_rd, contend} = '0;
    {crc_shifter_low, crc_engine_on, crc_engine_go, trig_src, ready_mode} = '0;
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    crc_engine_on <= 1'h1;
    crc_engine_go <= 1'h1;
    // Enable alone must leave the rest at reset values
    wr(OFS_CONTROL, 8'h80);
    rd(OFS_CONTROL, 8'h80, "control");
    rd(OFS_POLY_HIGH, 8'h00, "poly_high");
    rd(OFS_POLY_LOW, 8'h01, "poly_low");
    rd(OFS_CUR_UPPER, 8'h00, "cur_upper");
    rd(OFS_END_UPPER, 8'h3F, "end_upper");
    rd(OFS_END_HIGH, 8'hFF, "end_high");
    rd(OFS_END_LOW, 8'hFF, "end_low");
    rd(OFS_STATUS, 8'h00, "done_flag");
    rd(4'hF, 8'h00, "unmapped");
    // Live shifter view, writes refused; random taps with bit 0 stuck at one
    for (i = 0; i < 3; i++) begin
      v = 8'(xs());
      h = 8'(xs());
      crc_shifter_low <= v;
      wr(OFS_SHIFT_LOW, ~v);
      rd(OFS_SHIFT_LOW, v, "shift_low");
      wr(OFS_POLY_HIGH, h);
      wr(OFS_POLY_LOW, ~h);
      rd(OFS_POLY_HIGH, h, "poly_high");
      rd(OFS_POLY_LOW, ~h | 8'h01, "poly_low");
      chk("poly_tap", {16'h0, h, ~h[7:1], 1'h1}, {16'h0, poly_tap});
    end
    // Plain, burst and trigger scans under contention; pointer writes refused meanwhile
    contend <= 1'h1;
    for (i = 0; i < 3; i++) begin
      ctl = ctls[i];
      k = int'(xs() % 32'd10);
      ready_mode <= 2'(i == 1);
      trig_src <= 16'(xs()) & ~(16'h0001 << k);
      wr(OFS_TRIG_SEL, 8'(k));
      s = {2'h0, 20'(xs())};
      e = s + 22'h000006;
      scan_start(ctl, s, e, 1'b1);
      wr(OFS_CUR_LOW, 8'hFF);
      wr(OFS_END_LOW, s[7:0]);
      if (ctl[CTL_BURST]) begin
        chk("lower_blocked", 32'h1, {31'h0, lower_blocked});
        chk("lower_cycle_free", 32'h0, {31'h0, lower_cycle_free});
      end
      if (ctl[CTL_TRIG]) begin
        repeat (10) @(posedge clk);
        chk("mem_req", 32'h0, {31'h0, mem_req});
        chk("lower_cycle_free", 32'h1, {31'h0, lower_cycle_free});
        chk("words_left", 32'h7, 32'(data_q.size()));
        trig_src[k] <= 1'h1;
      end
      scan_end(ctl, e);
      chk("lower_blocked", 32'h0, {31'h0, lower_blocked});
      chk("lower_cycle_free", 32'h1, {31'h0, lower_cycle_free});
    end
    // Engine never ready: no request; engine go low clears scanner go
    ready_mode <= 2'h2;
    scan_start(8'hA0, 22'h000000, 22'h000010, 1'b0);
    repeat (5) @(posedge clk);
    chk("mem_req", 32'h0, {31'h0, mem_req});
    rd(OFS_CONTROL, 8'hA0, "control");
    crc_engine_go <= 1'h0;
    repeat (3) @(posedge clk);
    rd(OFS_CONTROL, 8'h80, "control");
    repeat (4) @(posedge clk);
    tally_and_finish();
  end
endmodule
